//--- hw/rtu_regs.svh
// Function codes, CRC constants, limits and timing counts for the RTU master
`ifndef RTU_REGS_SVH
`define RTU_REGS_SVH

`define FN_READ_REGS      8'h03
`define FN_WRITE_ONE      8'h06
`define FN_WRITE_MANY     8'h10
`define FN_EXC_BIT        8'h80

`define CRC_INIT          16'hFFFF
`define CRC_POLY          16'hA001
`define CRC_BITS          4'h8

`define MAX_WRITE_REGS    8'h3C
`define MAX_READ_REGS     8'h7D

`define CLK_PERIOD_NS     50
// 3.5 characters of 11 bits at 9600 baud
`define GAP_NS            4010417
`define GAP_CYCLES        ((`GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMEOUT_NS        100000000
`define TIMEOUT_CYCLES    (`TIMEOUT_NS / `CLK_PERIOD_NS)

`define FIFO_DEPTH        8
`endif

//--- hw/rtu_pkg.sv
// Types shared by the RTU master files
package rtu_pkg;
   typedef enum logic [2:0] {
      ST_OK        = 3'b000,
      ST_CRC_ERR   = 3'b001,
      ST_EXCEPTION = 3'b010,
      ST_TIMEOUT   = 3'b011,
      ST_BAD_REPLY = 3'b100,
      ST_BAD_REQ   = 3'b101
   } status_t;

   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,
      S_TX    = 3'b001,
      S_RX    = 3'b010,
      S_CHECK = 3'b011,
      S_DONE  = 3'b100
   } state_t;
endpackage

//--- hw/sync_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module sync_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic             mclk_in,
   input  wire logic             rst_b_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic             push;
   logic             pop;

   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_valid_out && out_ready_in;
   assign out_data_out  = mem_reg[rd_ptr_reg];
   assign out_valid_out = (count_reg != '0);

   always_ff @(posedge mclk_in) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data_in;
      end
   end

   // Ready is a flop so the top level drives it straight from a register
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         wr_ptr_reg   <= '0;
         rd_ptr_reg   <= '0;
         count_reg    <= '0;
         in_ready_out <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         count_reg    <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
         in_ready_out <= (count_reg + (AW+1)'(push) - (AW+1)'(pop)) != (AW+1)'(DEPTH);
      end
   end
endmodule

//--- hw/crc16_engine.sv
// Bit-serial reflected CRC-16 accumulator, one shift per clock
`timescale 1ns/10ps
`include "rtu_regs.svh"
module crc16_engine (
   input  wire logic        mclk_in,
   input  wire logic        rst_b_in,
   input  wire logic        init_in,
   input  wire logic        start_in,
   input  wire logic [7:0]  byte_in,
   output logic             busy_out,
   output logic      [15:0] crc_out
);
   logic [3:0] step_reg;

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         crc_out  <= `CRC_INIT;
         step_reg <= 4'h0;
         busy_out <= 1'b0;
      end else if (init_in) begin
         crc_out  <= `CRC_INIT;
         step_reg <= 4'h0;
         busy_out <= 1'b0;
      end else if (start_in) begin
         crc_out  <= crc_out ^ {8'h00, byte_in};
         step_reg <= 4'h0;
         busy_out <= 1'b1;
      end else if (busy_out) begin
         crc_out  <= {1'b0, crc_out[15:1]} ^ (crc_out[0] ? `CRC_POLY : 16'h0000);
         step_reg <= step_reg + 4'h1;
         busy_out <= (step_reg != `CRC_BITS - 4'h1);
      end
   end

   a_crc_init_value: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      init_in |=> crc_out == 16'hFFFF) else $error("CRC not preset to all ones");

   a_crc_eight_steps: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      (start_in && !init_in) |=> busy_out [*8] ##1 !busy_out)
      else $error("CRC byte did not take eight shifts");
endmodule

//--- hw/rtu_master.sv
// RTU serial master: builds request frames, sends them, checks the replies
//
// Contract
// - Function 03 reads, 06 writes one, 10 many
// - Read: address, 03, start, count, CRC
// - Single write: address, 06, register, data, CRC
// - Multi write: address, 10, start, count, bytes, data
// - Sixteen-bit words, most significant byte first
// - At most 60 registers per multi write
// - Sender appends CRC, receiver rechecks it
// - Only the eight data bits enter CRC
// - CRC accumulator starts at all ones
// - Each byte XORed into accumulator low byte
// - Shift right, XOR A001 when one drops out
// - Eight shift steps per byte
// - Appended CRC has its bytes swapped
`timescale 1ns/10ps
`include "rtu_regs.svh"
module rtu_master #(
   parameter int GAP_CYCLES     = `GAP_CYCLES,
   parameter int TIMEOUT_CYCLES = `TIMEOUT_CYCLES,
   parameter int FIFO_DEPTH     = `FIFO_DEPTH
) (
   input  wire logic             mclk_in,
   input  wire logic             rst_b_in,
   input  wire logic             cmd_valid_in,
   output logic                  cmd_ready_out,
   input  wire logic [7:0]       cmd_station_in,
   input  wire logic [7:0]       cmd_func_in,
   input  wire logic [15:0]      cmd_addr_in,
   input  wire logic [7:0]       cmd_count_in,
   input  wire logic             wdata_valid_in,
   output logic                  wdata_ready_out,
   input  wire logic [15:0]      wdata_in,
   output logic                  tx_valid_out,
   output logic      [7:0]       tx_data_out,
   input  wire logic             tx_ready_in,
   input  wire logic             rx_valid_in,
   input  wire logic [7:0]       rx_data_in,
   output logic                  rd_valid_out,
   output logic      [15:0]      rd_data_out,
   output logic                  done_out,
   output rtu_pkg::status_t      status_out,
   output logic      [7:0]       exc_code_out
);
   import rtu_pkg::*;

   logic        rst_s1_reg;
   logic        rst_b;
   state_t      state_reg;
   logic [8:0]  idx_reg;
   logic [7:0]  station_reg;
   logic [7:0]  func_reg;
   logic [15:0] addr_reg;
   logic [7:0]  count_reg;
   logic [15:0] last_word_reg;
   logic [8:0]  exp_len_reg;
   logic        bad_reg;
   logic        exc_reg;
   logic [7:0]  rd_hi_reg;
   logic [31:0] gap_cnt_reg;
   logic [31:0] wait_cnt_reg;
   logic        gap_ok;
   logic [8:0]  dlen;
   logic        fifo_valid;
   logic [15:0] fifo_data;
   logic        need_word;
   logic        tx_load;
   logic        pop;
   logic        rx_take;
   logic [7:0]  tx_byte;
   logic        crc_init;
   logic        crc_start;
   logic        crc_busy;
   logic [15:0] crc_val;
   logic        accept;

   function automatic logic [7:0] frame_byte(input logic [8:0]  idx,
                                             input logic [7:0]  fn,
                                             input logic [7:0]  st,
                                             input logic [15:0] addr,
                                             input logic [7:0]  cnt,
                                             input logic [15:0] word);
      logic [8:0] off;
      off = idx - 9'h007;
      case (idx)
         9'h000: frame_byte = st;
         9'h001: frame_byte = fn;
         9'h002: frame_byte = addr[15:8];
         9'h003: frame_byte = addr[7:0];
         9'h004: frame_byte = (fn == `FN_WRITE_ONE) ? word[15:8] : 8'h00;
         9'h005: frame_byte = (fn == `FN_WRITE_ONE) ? word[7:0] : cnt;
         9'h006: frame_byte = {cnt[6:0], 1'b0};
         default: frame_byte = off[0] ? word[7:0] : word[15:8];
      endcase
   endfunction

   function automatic logic req_ok(input logic [7:0] fn, input logic [7:0] cnt);
      case (fn)
         `FN_READ_REGS:  req_ok = (cnt != 8'h00) && (cnt <= `MAX_READ_REGS);
         `FN_WRITE_ONE:  req_ok = 1'b1;
         `FN_WRITE_MANY: req_ok = (cnt != 8'h00) && (cnt <= `MAX_WRITE_REGS);
         default:        req_ok = 1'b0;
      endcase
   endfunction

   // Reset release through two flops
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rst_s1_reg <= 1'b0;
         rst_b      <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_b      <= rst_s1_reg;
      end
   end

   sync_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_wfifo (
      .mclk_in       (mclk_in),
      .rst_b_in      (rst_b),
      .in_valid_in   (wdata_valid_in),
      .in_ready_out  (wdata_ready_out),
      .in_data_in    (wdata_in),
      .out_valid_out (fifo_valid),
      .out_ready_in  (pop),
      .out_data_out  (fifo_data)
   );

   crc16_engine u_crc (
      .mclk_in  (mclk_in),
      .rst_b_in (rst_b),
      .init_in  (crc_init),
      .start_in (crc_start),
      .byte_in  (tx_load ? tx_byte : rx_data_in),
      .busy_out (crc_busy),
      .crc_out  (crc_val)
   );

   assign accept    = cmd_valid_in && cmd_ready_out;
   assign dlen      = (func_reg == `FN_WRITE_MANY) ? 9'h007 + {count_reg, 1'b0} : 9'h006;
   assign need_word = (func_reg == `FN_WRITE_ONE && (idx_reg == 9'h004 || idx_reg == 9'h005)) ||
                      (func_reg == `FN_WRITE_MANY && idx_reg >= 9'h007 && idx_reg < dlen);
   assign gap_ok    = gap_cnt_reg >= 32'(GAP_CYCLES);
   // First byte waits for a quiet bus; the slave never speaks unasked
   assign tx_load   = state_reg == S_TX && !tx_valid_out && !crc_busy && (!need_word || fifo_valid) &&
                      idx_reg < dlen + 9'h002 && (idx_reg != 9'h000 || gap_ok);
   assign pop       = tx_load && need_word && (idx_reg == 9'h005 || (idx_reg >= 9'h007 && !idx_reg[0]));
   assign rx_take   = state_reg == S_RX && rx_valid_in;
   assign crc_start = (tx_load && idx_reg < dlen) || rx_take;
   assign crc_init  = accept || (state_reg == S_TX && idx_reg == dlen + 9'h002 && !tx_valid_out);

   // Swapped CRC: low byte of the accumulator goes out first
   always_comb begin
      if (idx_reg == dlen) begin
         tx_byte = crc_val[7:0];
      end else if (idx_reg == dlen + 9'h001) begin
         tx_byte = crc_val[15:8];
      end else begin
         tx_byte = frame_byte(idx_reg, func_reg, station_reg, addr_reg, count_reg, fifo_data);
      end
   end

   always_ff @(posedge mclk_in or negedge rst_b) begin
      if (!rst_b) begin
         station_reg   <= 8'h00;
         func_reg      <= 8'h00;
         addr_reg      <= 16'h0000;
         count_reg     <= 8'h00;
         last_word_reg <= 16'h0000;
      end else begin
         if (accept) begin
            station_reg <= cmd_station_in;
            func_reg    <= cmd_func_in;
            addr_reg    <= cmd_addr_in;
            count_reg   <= (cmd_func_in == `FN_WRITE_ONE) ? 8'h01 : cmd_count_in;
         end
         if (pop) begin
            last_word_reg <= fifo_data;
         end
      end
   end

   always_ff @(posedge mclk_in or negedge rst_b) begin
      if (!rst_b) begin
         tx_valid_out <= 1'b0;
         tx_data_out  <= 8'h00;
      end else if (tx_load) begin
         tx_valid_out <= 1'b1;
         tx_data_out  <= tx_byte;
      end else if (tx_ready_in) begin
         tx_valid_out <= 1'b0;
      end
   end

   // Any line activity restarts the idle gap measurement
   always_ff @(posedge mclk_in or negedge rst_b) begin
      if (!rst_b) begin
         gap_cnt_reg  <= 32'h0000_0000;
         wait_cnt_reg <= 32'h0000_0000;
      end else begin
         if (rx_valid_in || (tx_valid_out && tx_ready_in)) begin
            gap_cnt_reg <= 32'h0000_0000;
         end else if (!gap_ok) begin
            gap_cnt_reg <= gap_cnt_reg + 32'h0000_0001;
         end
         if (state_reg != S_RX || rx_take) begin
            wait_cnt_reg <= 32'h0000_0000;
         end else begin
            wait_cnt_reg <= wait_cnt_reg + 32'h0000_0001;
         end
      end
   end

   // Reply parsing
   always_ff @(posedge mclk_in or negedge rst_b) begin
      if (!rst_b) begin
         bad_reg      <= 1'b0;
         exc_reg      <= 1'b0;
         exp_len_reg  <= 9'h1FF;
         exc_code_out <= 8'h00;
         rd_hi_reg    <= 8'h00;
         rd_valid_out <= 1'b0;
         rd_data_out  <= 16'h0000;
      end else begin
         rd_valid_out <= 1'b0;
         if (accept) begin
            bad_reg      <= 1'b0;
            exc_reg      <= 1'b0;
            exp_len_reg  <= 9'h1FF;
            exc_code_out <= 8'h00;
         end else if (rx_take) begin
            if (idx_reg == 9'h000) begin
               bad_reg <= rx_data_in != station_reg;
            end else if (idx_reg == 9'h001) begin
               if (rx_data_in == (func_reg | `FN_EXC_BIT)) begin
                  exc_reg <= 1'b1;
               end else if (rx_data_in != func_reg) begin
                  bad_reg <= 1'b1;
               end
            end else if (idx_reg == 9'h002 && exc_reg) begin
               exc_code_out <= rx_data_in;
               exp_len_reg  <= 9'h005;
            end else if (idx_reg == 9'h002 && func_reg == `FN_READ_REGS) begin
               exp_len_reg <= {1'b0, rx_data_in} + 9'h005;
               if (rx_data_in != {count_reg[6:0], 1'b0}) begin
                  bad_reg <= 1'b1;
               end
            end else if (func_reg == `FN_READ_REGS && !exc_reg) begin
               if (idx_reg < exp_len_reg - 9'h002) begin
                  if (idx_reg[0]) begin
                     rd_hi_reg <= rx_data_in;
                  end else begin
                     rd_valid_out <= 1'b1;
                     rd_data_out  <= {rd_hi_reg, rx_data_in};
                  end
               end
            end else if (!exc_reg && idx_reg <= 9'h005) begin
               if (idx_reg == 9'h002) begin
                  exp_len_reg <= 9'h008;
               end
               if (rx_data_in != frame_byte(idx_reg, func_reg, station_reg, addr_reg, count_reg,
                                            last_word_reg)) begin
                  bad_reg <= 1'b1;
               end
            end
         end
      end
   end

   always_ff @(posedge mclk_in or negedge rst_b) begin
      if (!rst_b) begin
         state_reg     <= S_IDLE;
         idx_reg       <= 9'h000;
         cmd_ready_out <= 1'b1;
         done_out      <= 1'b0;
         status_out    <= ST_OK;
      end else begin
         done_out <= 1'b0;
         case (state_reg)
            S_IDLE: begin
               idx_reg <= 9'h000;
               if (accept) begin
                  cmd_ready_out <= 1'b0;
                  if (req_ok(cmd_func_in, cmd_count_in)) begin
                     state_reg <= S_TX;
                  end else begin
                     status_out <= ST_BAD_REQ;
                     state_reg  <= S_DONE;
                  end
               end
            end
            S_TX: begin
               if (tx_valid_out && tx_ready_in) begin
                  idx_reg <= idx_reg + 9'h001;
               end else if (crc_init) begin
                  idx_reg   <= 9'h000;
                  state_reg <= S_RX;
               end
            end
            S_RX: begin
               if (rx_take) begin
                  idx_reg <= idx_reg + 9'h001;
                  if (idx_reg + 9'h001 == exp_len_reg) begin
                     state_reg <= S_CHECK;
                  end
               end else if (idx_reg == 9'h000 && wait_cnt_reg >= 32'(TIMEOUT_CYCLES)) begin
                  status_out <= ST_TIMEOUT;
                  state_reg  <= S_DONE;
               end else if (idx_reg != 9'h000 && gap_ok) begin
                  status_out <= ST_BAD_REPLY;
                  state_reg  <= S_DONE;
               end
            end
            S_CHECK: begin
               // Running CRC over data plus its appended check leaves zero
               if (!crc_busy) begin
                  state_reg <= S_DONE;
                  if (crc_val != 16'h0000) begin
                     status_out <= ST_CRC_ERR;
                  end else if (bad_reg) begin
                     status_out <= ST_BAD_REPLY;
                  end else if (exc_reg) begin
                     status_out <= ST_EXCEPTION;
                  end else begin
                     status_out <= ST_OK;
                  end
               end
            end
            S_DONE: begin
               done_out      <= 1'b1;
               cmd_ready_out <= 1'b1;
               state_reg     <= S_IDLE;
            end
            default: begin
               state_reg <= S_IDLE;
            end
         endcase
      end
   end

   a_tx_gap_first: assert property (@(posedge mclk_in) disable iff (!rst_b)
      (tx_load && idx_reg == 9'h000) |-> gap_cnt_reg >= GAP_CYCLES) else $error("Frame started without gap");
   a_tx_func_legal: assert property (@(posedge mclk_in) disable iff (!rst_b)
      (tx_load && idx_reg == 9'h001) |=> tx_data_out inside {8'h03, 8'h06, 8'h10}) else $error("Bad function");
   a_tx_addr_msb: assert property (@(posedge mclk_in) disable iff (!rst_b)
      (tx_load && idx_reg == 9'h002) |=> tx_data_out == addr_reg[15:8]) else $error("Address not MSB first");
   a_tx_crc_swap: assert property (@(posedge mclk_in) disable iff (!rst_b)
      (tx_load && idx_reg == dlen) |=> tx_data_out == $past(crc_val[7:0])) else $error("CRC low byte not first");
   a_tx_hold_data: assert property (@(posedge mclk_in) disable iff (!rst_b)
      (tx_valid_out && !tx_ready_in) |=> tx_valid_out && $stable(tx_data_out)) else $error("Tx byte dropped");
   a_write_max_regs: assert property (@(posedge mclk_in) disable iff (!rst_b)
      (state_reg == S_TX && func_reg == 8'h10) |-> count_reg <= 8'h3C) else $error("Too many registers");
   a_ok_crc_zero: assert property (@(posedge mclk_in) disable iff (!rst_b)
      (state_reg == S_CHECK && !crc_busy && !bad_reg && !exc_reg && crc_val == 16'h0000) |=> status_out == ST_OK
      ##1 done_out) else $error("Good reply not reported");
   a_done_one_cycle: assert property (@(posedge mclk_in) disable iff (!rst_b)
      done_out |-> cmd_ready_out ##1 !done_out) else $error("Done not a single pulse");
   a_exc_status: assert property (@(posedge mclk_in) disable iff (!rst_b)
      (done_out && status_out == ST_EXCEPTION) |-> exc_reg && $past(crc_val, 2) == 16'h0000)
      else $error("Exception reported wrongly");
endmodule

//--- tb/rtu_slave_model.sv
// Behavioural slave: parameter table, CRC check and replies
`timescale 1ns/10ps
module rtu_slave_model (
   input  wire logic       mclk_in,
   input  wire logic       corrupt_in,
   input  wire logic       wrong_in,
   input  wire logic       tx_valid_in,
   input  wire logic [7:0] tx_data_in,
   output logic            tx_ready_out,
   output logic            rx_valid_out,
   output logic      [7:0] rx_data_out
);
   logic [15:0] tbl [0:511];
   logic [7:0]  req [$];
   logic [7:0]  rsp [$];
   logic [15:0] a, k, c;
   function automatic logic [15:0] crc16(input logic [7:0] q [$]);
      logic [15:0] r;
      r = 16'hFFFF;
      foreach (q[i]) begin
         r = r ^ {8'h00, q[i]};
         repeat (8) r = r[0] ? (r >> 1) ^ 16'hA001 : r >> 1;
      end
      return r;
   endfunction
   initial begin
      tx_ready_out = 1'b0;
      rx_valid_out = 1'b0;
      rx_data_out = 8'h00;
      foreach (tbl[i]) tbl[i] = 16'h0000;
      forever begin
         @(posedge mclk_in);
         if (tx_valid_in && tx_ready_out) req.push_back(tx_data_in);
         // Half-rate acceptance keeps the master stalling
         tx_ready_out <= ~tx_ready_out;
         if (req.size() == ((req.size() > 6 && req[1] == 8'h10) ? 9 + req[6] : 8)) begin
            rsp.delete();
            a = {req[2], req[3]};
            k = {req[4], req[5]};
            if (req[0] == 8'h01 && crc16(req) == 16'h0000) begin
               rsp = req[0:5];
               if (req[1] != 8'h03 && req[1] != 8'h06 && req[1] != 8'h10) rsp = '{req[0], req[1] | 8'h80, 8'h81};
               else if (req[1] != 8'h06 && a + k > 512) rsp = '{req[0], req[1] | 8'h80, 8'h82};
               else if (req[1] == 8'h06) tbl[a] = k;
               else if (req[1] == 8'h10) for (int i = 0; i < k; i++) tbl[a + i] = {req[7 + 2 * i], req[8 + 2 * i]};
               else begin
                  rsp = '{req[0], req[1], 8'(2 * k)};
                  for (int i = 0; i < k; i++) rsp = {rsp, tbl[a + i][15:8], tbl[a + i][7:0]};
               end
               if (wrong_in) rsp[0] = 8'h05;
               c = crc16(rsp);
               rsp = {rsp, c[7:0], c[15:8] ^ {8{corrupt_in}}};
            end
            req.delete();
            foreach (rsp[i]) begin
               repeat (12) @(posedge mclk_in);
               rx_valid_out <= 1'b1;
               rx_data_out <= rsp[i];
               @(posedge mclk_in);
               rx_valid_out <= 1'b0;
               // Idle line must not keep showing the last byte
               rx_data_out <= ~rsp[i];
            end
         end
      end
   end
endmodule

//--- tb/tb_rtu_master.sv
// Self-checking bench: RTU master against the slave model
`timescale 1ns/10ps
module tb_rtu_master;
   import rtu_pkg::*;
   logic        mclk_in, rst_b_in, cmd_valid_in, cmd_ready_out, wdata_valid_in, wdata_ready_out, corrupt, wrong;
   logic        tx_valid_out, tx_ready_in, rx_valid_in, rd_valid_out, done_out;
   logic [7:0]  cmd_station_in, cmd_func_in, cmd_count_in, tx_data_out, rx_data_in, exc_code_out;
   logic [15:0] cmd_addr_in, wdata_in, rd_data_out;
   status_t     status_out;
   logic [7:0]  txq [$];
   logic [15:0] rdq [$];
   int          fails, samples_checked;
   rtu_master #(.GAP_CYCLES(20), .TIMEOUT_CYCLES(200)) rtu_master_i (.mclk_in, .rst_b_in, .cmd_valid_in,
      .cmd_ready_out, .cmd_station_in, .cmd_func_in, .cmd_addr_in, .cmd_count_in, .wdata_valid_in,
      .wdata_ready_out, .wdata_in, .tx_valid_out, .tx_data_out, .tx_ready_in, .rx_valid_in, .rx_data_in,
      .rd_valid_out, .rd_data_out, .done_out, .status_out, .exc_code_out);
   rtu_slave_model rtu_slave_model_i (.mclk_in, .corrupt_in(corrupt), .wrong_in(wrong), .tx_valid_in(tx_valid_out),
      .tx_data_in(tx_data_out), .tx_ready_out(tx_ready_in), .rx_valid_out(rx_valid_in), .rx_data_out(rx_data_in));
   initial begin
      mclk_in = 1'b0;
      forever #25 mclk_in = ~mclk_in;
   end
   always @(posedge mclk_in) begin
      if (tx_valid_out === 1'b1 && tx_ready_in === 1'b1) txq.push_back(tx_data_out);
      if (rd_valid_out === 1'b1) rdq.push_back(rd_data_out);
   end
   task automatic close_out;
      if (fails == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      samples_checked++;
      if (ok !== 1'b1) begin
         fails++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask
   task automatic push(input logic [15:0] w);
      wdata_valid_in = 1'b1;
      wdata_in = w;
      @(posedge mclk_in);
      #2;
   endtask
   task automatic run(input logic [7:0] st, fn, input logic [15:0] ad, input logic [7:0] ct, input status_t es);
      int n;
      txq.delete();
      rdq.delete();
      chk(cmd_ready_out === 1'b1, "master not ready");
      {cmd_station_in, cmd_func_in, cmd_addr_in, cmd_count_in} = {st, fn, ad, ct};
      cmd_valid_in = 1'b1;
      @(posedge mclk_in);
      #2 cmd_valid_in = 1'b0;
      for (n = 0; n < 4000 && done_out !== 1'b1; n++) begin
         @(posedge mclk_in);
         #1;
      end
      if (n == 4000) begin
         chk(1'b0, "no done");
         close_out();
      end else begin
         #1 chk(status_out === es, "status");
      end
   endtask
   task automatic frame(input logic [7:0] e [$]);
      chk(txq.size() == e.size(), "frame length");
      foreach (e[i]) chk(txq[i] === e[i], "frame byte");
   endtask
   task automatic t_bad_req;
      run(8'h01, 8'h07, 16'h0000, 8'h01, ST_BAD_REQ);
      run(8'h01, 8'h10, 16'h0000, 8'd61, ST_BAD_REQ);
      chk(txq.size() == 0, "bytes sent for bad request");
   endtask
   task automatic t_fifo;
      for (int i = 0; i < 8; i++) push(16'hA000 + 16'(i));
      chk(wdata_ready_out === 1'b0, "fifo not full");
      // Refused word would corrupt the next write
      push(16'hFFFF);
      wdata_valid_in = 1'b0;
      run(8'h01, 8'h10, 16'h0020, 8'h08, ST_OK);
      run(8'h01, 8'h03, 16'h0020, 8'h08, ST_OK);
      chk(rdq.size() == 8, "read count");
      foreach (rdq[i]) chk(rdq[i] === 16'hA000 + 16'(i), "read order");
   endtask
   task automatic t_many_read;
      push(16'h0005);
      push(16'h0004);
      wdata_valid_in = 1'b0;
      run(8'h01, 8'h10, 16'h0009, 8'h02, ST_OK);
      frame('{8'h01, 8'h10, 8'h00, 8'h09, 8'h00, 8'h02, 8'h04, 8'h00, 8'h05, 8'h00, 8'h04, 8'h22, 8'h07});
      run(8'h01, 8'h03, 16'h0009, 8'h02, ST_OK);
      frame('{8'h01, 8'h03, 8'h00, 8'h09, 8'h00, 8'h02, 8'h14, 8'h09});
      chk(rdq.size() == 2 && rdq[0] === 16'h0005 && rdq[1] === 16'h0004, "read data");
      run(8'h01, 8'h03, 16'h0116, 8'h03, ST_OK);
      frame('{8'h01, 8'h03, 8'h01, 8'h16, 8'h00, 8'h03, 8'hE5, 8'hF3});
   endtask
   task automatic t_write_one;
      push(16'h07D0);
      wdata_valid_in = 1'b0;
      run(8'h01, 8'h06, 16'h002C, 8'h01, ST_OK);
      frame('{8'h01, 8'h06, 8'h00, 8'h2C, 8'h07, 8'hD0, 8'h4B, 8'hAF});
      run(8'h01, 8'h03, 16'h002C, 8'h01, ST_OK);
      chk(rdq.size() == 1 && rdq[0] === 16'h07D0, "single write");
   endtask
   task automatic t_errors;
      run(8'h01, 8'h03, 16'h01FE, 8'h04, ST_EXCEPTION);
      chk(exc_code_out === 8'h82, "exception code");
      run(8'h02, 8'h03, 16'h0000, 8'h01, ST_TIMEOUT);
      corrupt = 1'b1;
      run(8'h01, 8'h03, 16'h0000, 8'h01, ST_CRC_ERR);
      corrupt = 1'b0;
      wrong = 1'b1;
      run(8'h01, 8'h03, 16'h0000, 8'h01, ST_BAD_REPLY);
      wrong = 1'b0;
   endtask
   initial begin
      {rst_b_in, cmd_valid_in, wdata_valid_in, corrupt, wrong} = 5'h00;
      {cmd_station_in, cmd_func_in, cmd_addr_in, cmd_count_in, wdata_in} = 56'h0;
      repeat (16) @(posedge mclk_in);
      #2 rst_b_in = 1'b1;
      repeat (3) @(posedge mclk_in);
      #2 t_bad_req();
      t_fifo();
      t_many_read();
      t_write_one();
      t_errors();
      close_out();
   end
endmodule
